// ===== hdl/tmw_pkg.sv
// constants shared by the 16-bit timer waveform block
// assumes one system clock and an external prescaler tick enable
// ==========================================================
package tmw_pkg;
  localparam logic [3:0] TMW_MODE_PC8 = 4'h1;
  localparam logic [3:0] TMW_MODE_PC9 = 4'h2;
  localparam logic [3:0] TMW_MODE_PC10 = 4'h3;
  localparam logic [3:0] TMW_MODE_CTC_A = 4'h4;
  localparam logic [3:0] TMW_MODE_FP8 = 4'h5;
  localparam logic [3:0] TMW_MODE_FP9 = 4'h6;
  localparam logic [3:0] TMW_MODE_FP10 = 4'h7;
  localparam logic [3:0] TMW_MODE_PC_CAP = 4'hA;
  localparam logic [3:0] TMW_MODE_PC_A = 4'hB;
  localparam logic [3:0] TMW_MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] TMW_MODE_FP_CAP = 4'hE;
  localparam logic [3:0] TMW_MODE_FP_A = 4'hF;
  localparam logic [15:0] TMW_TOP8 = 16'h00FF;
  localparam logic [15:0] TMW_TOP9 = 16'h01FF;
  localparam logic [15:0] TMW_TOP10 = 16'h03FF;
  localparam logic [15:0] TMW_MAX = 16'hFFFF;
  localparam logic [15:0] TMW_BOTTOM = 16'h0000;
  localparam logic [15:0] TMW_ONE = 16'h0001;
  localparam logic [1:0] TMW_ACT_NONE = 2'h0;
  localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMW_ACT_NONINV = 2'h2;
  localparam logic [1:0] TMW_ACT_INV = 2'h3;
  // register indices
  localparam logic [2:0] TMW_REG_CTRL = 3'h0;
  localparam logic [2:0] TMW_REG_COUNT = 3'h1;
  localparam logic [2:0] TMW_REG_CMPA = 3'h2;
  localparam logic [2:0] TMW_REG_CAPTOP = 3'h3;
  localparam logic [2:0] TMW_REG_FLAGS = 3'h4;
  localparam logic [2:0] TMW_REG_CMPB = 3'h5;
  // control register fields
  localparam int TMW_CTRL_MODE_LSB = 0;
  localparam int TMW_CTRL_ACTA_LSB = 4;
  localparam int TMW_CTRL_ACTB_LSB = 6;
  localparam int TMW_CTRL_DIRA_BIT = 8;
  localparam int TMW_CTRL_DIRB_BIT = 9;
  // flag register fields, write one to clear
  localparam int TMW_FLG_OVF_BIT = 0;
  localparam int TMW_FLG_MATCHA_BIT = 1;
  localparam int TMW_FLG_MATCHB_BIT = 2;
  localparam int TMW_FLG_CAPT_BIT = 3;
  typedef enum logic [1:0] {TMW_KIND_NORMAL, TMW_KIND_CTC, TMW_KIND_FAST, TMW_KIND_PC} tmw_kind_t;
endpackage

// ===== hdl/tmw_timer.sv
// 16-bit timer waveform generator: clear-on-match, fast PWM, phase correct PWM
// assumes a prescaler tick pulse synchronous to clk_in and a simple register port
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module tmw_timer
#(
  parameter int WIDTH = 16
)
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic tick_in,
  input wire logic [2:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic wave_pin_a_out,
  output logic wave_pin_a_oe_n_out,
  output logic wave_pin_b_out,
  output logic wave_pin_b_oe_n_out,
  output logic overflow_flag_out,
  output logic match_flag_a_out,
  output logic capture_flag_out
);
  // ==========================================================
  // decode helpers
  function automatic tmw_pkg::tmw_kind_t kind_of(input logic [3:0] m);
    case (m)
      tmw_pkg::TMW_MODE_CTC_A, tmw_pkg::TMW_MODE_CTC_CAP:
        kind_of = tmw_pkg::TMW_KIND_CTC;
      tmw_pkg::TMW_MODE_FP8, tmw_pkg::TMW_MODE_FP9, tmw_pkg::TMW_MODE_FP10,
      tmw_pkg::TMW_MODE_FP_CAP, tmw_pkg::TMW_MODE_FP_A:
        kind_of = tmw_pkg::TMW_KIND_FAST;
      tmw_pkg::TMW_MODE_PC8, tmw_pkg::TMW_MODE_PC9, tmw_pkg::TMW_MODE_PC10,
      tmw_pkg::TMW_MODE_PC_CAP, tmw_pkg::TMW_MODE_PC_A:
        kind_of = tmw_pkg::TMW_KIND_PC;
      default:
        kind_of = tmw_pkg::TMW_KIND_NORMAL;
    endcase
  endfunction

  // fixed-width mask, all ones when top is register defined
  function automatic logic [WIDTH-1:0] fixed_mask(input logic [3:0] m);
    case (m)
      tmw_pkg::TMW_MODE_PC8, tmw_pkg::TMW_MODE_FP8:
        fixed_mask = tmw_pkg::TMW_TOP8;
      tmw_pkg::TMW_MODE_PC9, tmw_pkg::TMW_MODE_FP9:
        fixed_mask = tmw_pkg::TMW_TOP9;
      tmw_pkg::TMW_MODE_PC10, tmw_pkg::TMW_MODE_FP10:
        fixed_mask = tmw_pkg::TMW_TOP10;
      default:
        fixed_mask = tmw_pkg::TMW_MAX;
    endcase
  endfunction

  // ==========================================================
  // registers
  logic [3:0] mode_q;
  logic [1:0] act_q [2];
  logic [1:0] dir_q;
  logic [WIDTH-1:0] count_q;
  logic down_q;
  logic [WIDTH-1:0] cmp_buf_q [2];
  logic [WIDTH-1:0] cmp_q [2];
  logic [WIDTH-1:0] cap_top_q;
  logic ovf_q;
  logic [1:0] mflag_q;
  logic capf_q;
  logic [1:0] wave_q;

  tmw_pkg::tmw_kind_t kind;
  logic [WIDTH-1:0] top;
  logic top_hit;
  logic at_bottom;
  logic at_max;
  logic buffered;
  logic top_is_a;
  logic top_is_cap;
  logic [WIDTH-1:0] mask;
  logic [WIDTH-1:0] wmask;
  logic [1:0] cmp_hit;
  logic wr_ctrl;
  logic wr_flags;

  assign kind = kind_of(mode_q);
  assign mask = fixed_mask(mode_q);
  assign wmask = wdata_in[WIDTH-1:0] & mask;
  assign top_is_a = (mode_q == tmw_pkg::TMW_MODE_CTC_A) || (mode_q == tmw_pkg::TMW_MODE_FP_A)
                    || (mode_q == tmw_pkg::TMW_MODE_PC_A);
  assign top_is_cap = (mode_q == tmw_pkg::TMW_MODE_CTC_CAP)
                      || (mode_q == tmw_pkg::TMW_MODE_FP_CAP)
                      || (mode_q == tmw_pkg::TMW_MODE_PC_CAP);
  assign buffered = (kind == tmw_pkg::TMW_KIND_FAST) || (kind == tmw_pkg::TMW_KIND_PC);
  assign wr_ctrl = wr_in && (addr_in == tmw_pkg::TMW_REG_CTRL);
  assign wr_flags = wr_in && (addr_in == tmw_pkg::TMW_REG_FLAGS);

  // ==========================================================
  // top selection
  always_comb
  begin
    if (top_is_a)
      top = cmp_q[0];
    else if (top_is_cap)
      top = cap_top_q;
    else if (kind == tmw_pkg::TMW_KIND_NORMAL)
      top = tmw_pkg::TMW_MAX;
    else
      top = mask;
  end

  assign top_hit = (count_q == top);
  assign at_bottom = (count_q == tmw_pkg::TMW_BOTTOM);
  assign at_max = (count_q == tmw_pkg::TMW_MAX);

  // ==========================================================
  // control register
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mode_q <= 4'h0;
      act_q[0] <= tmw_pkg::TMW_ACT_NONE;
      act_q[1] <= tmw_pkg::TMW_ACT_NONE;
      dir_q <= 2'h0;
    end
    else if (wr_ctrl)
    begin
      mode_q <= wdata_in[tmw_pkg::TMW_CTRL_MODE_LSB +: 4];
      act_q[0] <= wdata_in[tmw_pkg::TMW_CTRL_ACTA_LSB +: 2];
      act_q[1] <= wdata_in[tmw_pkg::TMW_CTRL_ACTB_LSB +: 2];
      dir_q <= wdata_in[tmw_pkg::TMW_CTRL_DIRA_BIT +: 2];
    end
  end

  // ==========================================================
  // counter and direction
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      count_q <= tmw_pkg::TMW_BOTTOM;
      down_q <= 1'b0;
    end
    else if (wr_in && (addr_in == tmw_pkg::TMW_REG_COUNT))
      count_q <= wdata_in[WIDTH-1:0];
    else if (tick_in)
    begin
      case (kind)
        tmw_pkg::TMW_KIND_CTC, tmw_pkg::TMW_KIND_FAST:
        begin
          down_q <= 1'b0;
          if (top_hit)
            count_q <= tmw_pkg::TMW_BOTTOM;
          else
            count_q <= count_q + tmw_pkg::TMW_ONE;
        end
        tmw_pkg::TMW_KIND_PC:
        begin
          if (top_hit && !down_q)
          begin
            down_q <= 1'b1;
            count_q <= count_q - tmw_pkg::TMW_ONE;
          end
          else if (down_q && at_bottom)
          begin
            down_q <= 1'b0;
            count_q <= count_q + tmw_pkg::TMW_ONE;
          end
          else if (down_q)
            count_q <= count_q - tmw_pkg::TMW_ONE;
          else
            count_q <= count_q + tmw_pkg::TMW_ONE;
        end
        default:
        begin
          down_q <= 1'b0;
          count_q <= count_q + tmw_pkg::TMW_ONE;
        end
      endcase
    end
  end

  // ==========================================================
  // compare registers, buffered in PWM kinds
  generate
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_cmp
      logic wr_cmp;
      assign wr_cmp = wr_in && (addr_in == (ch == 0 ? tmw_pkg::TMW_REG_CMPA
                                                    : tmw_pkg::TMW_REG_CMPB));
      assign cmp_hit[ch] = (count_q == cmp_q[ch]);
      always_ff @(posedge clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          cmp_buf_q[ch] <= tmw_pkg::TMW_BOTTOM;
          cmp_q[ch] <= tmw_pkg::TMW_BOTTOM;
        end
        else
        begin
          if (wr_cmp)
            cmp_buf_q[ch] <= wmask;
          if (wr_cmp && !buffered)
            cmp_q[ch] <= wmask;
          else if (tick_in && buffered && top_hit && !down_q)
            cmp_q[ch] <= cmp_buf_q[ch];
        end
      end

      // waveform bit
      always_ff @(posedge clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
          wave_q[ch] <= 1'b0;
        else if (tick_in)
        begin
          case (kind)
            tmw_pkg::TMW_KIND_FAST:
            begin
              if (act_q[ch] == tmw_pkg::TMW_ACT_TOGGLE && ch == 0 && cmp_hit[ch])
                wave_q[ch] <= ~wave_q[ch];
              else if (act_q[ch][1] && cmp_hit[ch])
                wave_q[ch] <= ~act_q[ch][0];
              else if (act_q[ch][1] && top_hit)
                wave_q[ch] <= act_q[ch][0];
            end
            tmw_pkg::TMW_KIND_PC:
            begin
              if (act_q[ch][1] && cmp_hit[ch])
                wave_q[ch] <= act_q[ch][0] ^ down_q;
            end
            default:
            begin
              if (cmp_hit[ch])
              begin
                case (act_q[ch])
                  tmw_pkg::TMW_ACT_TOGGLE: wave_q[ch] <= ~wave_q[ch];
                  tmw_pkg::TMW_ACT_NONINV: wave_q[ch] <= 1'b0;
                  tmw_pkg::TMW_ACT_INV: wave_q[ch] <= 1'b1;
                  default: wave_q[ch] <= wave_q[ch];
                endcase
              end
            end
          endcase
        end
      end
    end
  endgenerate

  // ==========================================================
  // capture top register, never buffered
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cap_top_q <= tmw_pkg::TMW_BOTTOM;
    else if (wr_in && (addr_in == tmw_pkg::TMW_REG_CAPTOP))
      cap_top_q <= wdata_in[WIDTH-1:0];
  end

  // ==========================================================
  // flags, set wins over write-one-to-clear
  logic ovf_set;
  logic [1:0] mflag_set;
  logic capf_set;

  always_comb
  begin
    ovf_set = 1'b0;
    if (tick_in)
    begin
      case (kind)
        tmw_pkg::TMW_KIND_FAST: ovf_set = top_hit;
        tmw_pkg::TMW_KIND_PC: ovf_set = at_bottom && down_q;
        default: ovf_set = at_max;
      endcase
    end
  end

  assign capf_set = tick_in && top_is_cap && top_hit && !down_q;
  assign mflag_set[0] = tick_in && cmp_hit[0];
  assign mflag_set[1] = tick_in && cmp_hit[1];

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ovf_q <= 1'b0;
      mflag_q <= 2'h0;
      capf_q <= 1'b0;
    end
    else
    begin
      ovf_q <= ovf_set || (ovf_q && !(wr_flags && wdata_in[tmw_pkg::TMW_FLG_OVF_BIT]));
      mflag_q[0] <= mflag_set[0]
                    || (mflag_q[0] && !(wr_flags && wdata_in[tmw_pkg::TMW_FLG_MATCHA_BIT]));
      mflag_q[1] <= mflag_set[1]
                    || (mflag_q[1] && !(wr_flags && wdata_in[tmw_pkg::TMW_FLG_MATCHB_BIT]));
      capf_q <= capf_set || (capf_q && !(wr_flags && wdata_in[tmw_pkg::TMW_FLG_CAPT_BIT]));
    end
  end

  // ==========================================================
  // outputs and read port
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wave_pin_a_out <= 1'b0;
      wave_pin_a_oe_n_out <= 1'b1;
      wave_pin_b_out <= 1'b0;
      wave_pin_b_oe_n_out <= 1'b1;
      overflow_flag_out <= 1'b0;
      match_flag_a_out <= 1'b0;
      capture_flag_out <= 1'b0;
    end
    else
    begin
      wave_pin_a_out <= dir_q[0] && wave_q[0];
      wave_pin_a_oe_n_out <= ~dir_q[0];
      wave_pin_b_out <= dir_q[1] && wave_q[1];
      wave_pin_b_oe_n_out <= ~dir_q[1];
      overflow_flag_out <= ovf_set || ovf_q;
      match_flag_a_out <= mflag_set[0] || mflag_q[0];
      capture_flag_out <= capf_set || capf_q;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rdata_out <= 16'h0000;
    else if (rd_in)
    begin
      case (addr_in)
        tmw_pkg::TMW_REG_CTRL:
          rdata_out <= {6'h00, dir_q, act_q[1], act_q[0], mode_q};
        tmw_pkg::TMW_REG_COUNT: rdata_out <= count_q;
        tmw_pkg::TMW_REG_CMPA: rdata_out <= cmp_buf_q[0];
        tmw_pkg::TMW_REG_CAPTOP: rdata_out <= cap_top_q;
        tmw_pkg::TMW_REG_FLAGS: rdata_out <= {12'h000, capf_q, mflag_q, ovf_q};
        tmw_pkg::TMW_REG_CMPB: rdata_out <= cmp_buf_q[1];
        default: rdata_out <= 16'h0000;
      endcase
    end
    else
      rdata_out <= 16'h0000;
  end

  // ==========================================================
  // checks
  property p_ctc_clear;
    @(posedge clk_in) disable iff (!arst_n_in)
    (kind == tmw_pkg::TMW_KIND_CTC && tick_in && top_hit && !wr_in) |=> count_q == 16'h0000;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc clear missed");

  property p_fast_ovf;
    @(posedge clk_in) disable iff (!arst_n_in)
    (kind == tmw_pkg::TMW_KIND_FAST && tick_in && top_hit) |=> ovf_q;
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("fast ovf not set");

  property p_pin_dir;
    @(posedge clk_in) disable iff (!arst_n_in)
    !dir_q[0] |=> wave_pin_a_oe_n_out && !wave_pin_a_out;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin driven while input");

  property p_idle;
    @(posedge clk_in) disable iff (!arst_n_in)
    (!tick_in && !wr_in) |=> $stable(count_q) && $stable(wave_q);
  endproperty
  a_idle: assert property (p_idle) else $error("action between ticks");

  property p_toggle;
    @(posedge clk_in) disable iff (!arst_n_in)
    (kind == tmw_pkg::TMW_KIND_CTC && act_q[0] == tmw_pkg::TMW_ACT_TOGGLE && tick_in
     && cmp_hit[0]) |=> wave_q[0] != $past(wave_q[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed");

  property p_ovf_ctc;
    @(posedge clk_in) disable iff (!arst_n_in)
    (kind == tmw_pkg::TMW_KIND_CTC && tick_in && at_max) |=> ovf_q;
  endproperty
  a_ovf_ctc: assert property (p_ovf_ctc) else $error("ctc overflow missed");

  property p_pc_ovf;
    @(posedge clk_in) disable iff (!arst_n_in)
    (kind == tmw_pkg::TMW_KIND_PC && tick_in && at_bottom && down_q) |=> ovf_q;
  endproperty
  a_pc_ovf: assert property (p_pc_ovf) else $error("pc overflow missed");

  property p_noninv;
    @(posedge clk_in) disable iff (!arst_n_in)
    (kind == tmw_pkg::TMW_KIND_FAST && act_q[0] == tmw_pkg::TMW_ACT_NONINV && tick_in
     && cmp_hit[0]) |=> wave_q[0];
  endproperty
  a_noninv: assert property (p_noninv) else $error("noninv set missed");
endmodule

// ===== tb/tmw_timer_tb.sv
// self-checking bench for the timer waveform block
// assumes tmw_pkg compiled first; bench drives every input port of the block directly
`timescale 1ns/100ps
module tmw_timer_tb;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic tick_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic wave_pin_a_out, wave_pin_a_oe_n_out, wave_pin_b_out, wave_pin_b_oe_n_out;
  logic overflow_flag_out, match_flag_a_out, capture_flag_out;
  int err_count = 0;
  int n_compared = 0;
  logic p;

  tmw_timer dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .tick_in(tick_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .wave_pin_a_out(wave_pin_a_out),
    .wave_pin_a_oe_n_out(wave_pin_a_oe_n_out), .wave_pin_b_out(wave_pin_b_out),
    .wave_pin_b_oe_n_out(wave_pin_b_oe_n_out), .overflow_flag_out(overflow_flag_out),
    .match_flag_a_out(match_flag_a_out), .capture_flag_out(capture_flag_out));

  // ==========================================================
  // clock, reset, watchdog
  initial
  begin
    forever #20 clk_in = ~clk_in;
  end

  initial
  begin
    #(40 * 20000);
    err_count++;
    report_and_stop();
  end

  // ==========================================================
  // bus and check helpers
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
  endtask

  task automatic chk_rd(input string name, input logic [2:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask

  // ticks are single cycles with settle time so registered outputs have landed
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      tick_in <= 1'b1;
      @(posedge clk_in);
      tick_in <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
    @(negedge clk_in);
  endtask

  function automatic logic [15:0] ctrl(input logic [3:0] mode, input logic [1:0] act,
                                       input logic dir);
    return {7'h00, dir, 2'h0, act, mode};
  endfunction

  task automatic clr_flags();
    wr(tmw_pkg::TMW_REG_FLAGS, 16'h000F);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    @(negedge clk_in);
    chk("pin_a", 16'h0000, {15'h0, wave_pin_a_out});
    chk("oe_n_a", 16'h0001, {15'h0, wave_pin_a_oe_n_out});
    chk("pin_b", 16'h0000, {15'h0, wave_pin_b_out});
    chk("oe_n_b", 16'h0001, {15'h0, wave_pin_b_oe_n_out});
    chk("ovf", 16'h0000, {15'h0, overflow_flag_out});
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0000);
    chk_rd("unmapped6", 3'h6, 16'h0000);
    chk_rd("unmapped7", 3'h7, 16'h0000);
  endtask

  task automatic t_ctc_a();
    wr(tmw_pkg::TMW_REG_CMPA, 16'h0003);
    wr(tmw_pkg::TMW_REG_CTRL, ctrl(tmw_pkg::TMW_MODE_CTC_A, 2'h1, 1'b1));
    wr(tmw_pkg::TMW_REG_COUNT, 16'h0000);
    clr_flags();
    step(3);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0003);
    chk("flag_a", 16'h0000, {15'h0, match_flag_a_out});
    step(1);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0000);
    chk("flag_a", 16'h0001, {15'h0, match_flag_a_out});
    chk("pin_a", 16'h0001, {15'h0, wave_pin_a_out});
    chk("oe_n_a", 16'h0000, {15'h0, wave_pin_a_oe_n_out});
    step(4);
    chk("pin_a", 16'h0000, {15'h0, wave_pin_a_out});
    step(4);
    wr(tmw_pkg::TMW_REG_CTRL, ctrl(tmw_pkg::TMW_MODE_CTC_A, 2'h1, 1'b0));
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk("pin_a", 16'h0000, {15'h0, wave_pin_a_out});
    chk("oe_n_a", 16'h0001, {15'h0, wave_pin_a_oe_n_out});
    wr(tmw_pkg::TMW_REG_CTRL, ctrl(tmw_pkg::TMW_MODE_CTC_A, 2'h0, 1'b1));
    step(4);
    chk("pin_a", 16'h0001, {15'h0, wave_pin_a_out});
    step(2);
    repeat (20) @(posedge clk_in);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0002);
    wr(tmw_pkg::TMW_REG_COUNT, 16'hFFFE);
    clr_flags();
    wr(tmw_pkg::TMW_REG_CMPA, 16'h0002);
    step(2);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0000);
    chk("ovf", 16'h0001, {15'h0, overflow_flag_out});
    chk("flag_a", 16'h0000, {15'h0, match_flag_a_out});
    step(3);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0000);
    chk("flag_a", 16'h0001, {15'h0, match_flag_a_out});
  endtask

  task automatic t_ctc_cap();
    wr(tmw_pkg::TMW_REG_CTRL, ctrl(tmw_pkg::TMW_MODE_CTC_CAP, 2'h0, 1'b1));
    wr(tmw_pkg::TMW_REG_CAPTOP, 16'h0002);
    wr(tmw_pkg::TMW_REG_CMPA, 16'h00FF);
    wr(tmw_pkg::TMW_REG_COUNT, 16'h0000);
    clr_flags();
    step(3);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0000);
    chk("cap_flag", 16'h0001, {15'h0, capture_flag_out});
    chk("flag_a", 16'h0000, {15'h0, match_flag_a_out});
    // channel B toggles and drives its pin, channel A pin released
    wr(tmw_pkg::TMW_REG_CMPB, 16'h0001);
    wr(tmw_pkg::TMW_REG_CTRL, 16'h024C);
    step(3);
    chk("pin_b", 16'h0001, {15'h0, wave_pin_b_out});
    chk("oe_n_b", 16'h0000, {15'h0, wave_pin_b_oe_n_out});
    chk("pin_a", 16'h0000, {15'h0, wave_pin_a_out});
    chk("oe_n_a", 16'h0001, {15'h0, wave_pin_a_oe_n_out});
  endtask

  task automatic t_fast_cap();
    wr(tmw_pkg::TMW_REG_CMPA, 16'h0002);
    wr(tmw_pkg::TMW_REG_CAPTOP, 16'h0005);
    for (int a = 2; a <= 3; a++)
    begin
      wr(tmw_pkg::TMW_REG_CTRL, ctrl(tmw_pkg::TMW_MODE_FP_CAP, a[1:0], 1'b1));
      wr(tmw_pkg::TMW_REG_COUNT, 16'h0000);
      clr_flags();
      step(3);
      chk("pin_a", {15'h0, a == 2}, {15'h0, wave_pin_a_out});
      step(2);
      chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0005);
      chk("ovf", 16'h0000, {15'h0, overflow_flag_out});
      step(1);
      chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0000);
      chk("pin_a", {15'h0, a == 3}, {15'h0, wave_pin_a_out});
      chk("ovf", 16'h0001, {15'h0, overflow_flag_out});
      chk("cap_flag", 16'h0001, {15'h0, capture_flag_out});
    end
    // unbuffered top written below the count: wrap through max first
    clr_flags();
    wr(tmw_pkg::TMW_REG_COUNT, 16'hFFFE);
    wr(tmw_pkg::TMW_REG_CAPTOP, 16'h0003);
    step(2);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0000);
    chk("cap_flag", 16'h0000, {15'h0, capture_flag_out});
    step(4);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0000);
    chk("cap_flag", 16'h0001, {15'h0, capture_flag_out});
  endtask

  task automatic t_fixed_top();
    logic [15:0] tops [3];
    logic [3:0] modes [3];
    tops = '{tmw_pkg::TMW_TOP8, tmw_pkg::TMW_TOP9, tmw_pkg::TMW_TOP10};
    modes = '{tmw_pkg::TMW_MODE_FP8, tmw_pkg::TMW_MODE_FP9, tmw_pkg::TMW_MODE_FP10};
    for (int i = 0; i < 3; i++)
    begin
      wr(tmw_pkg::TMW_REG_CTRL, ctrl(modes[i], 2'h0, 1'b1));
      wr(tmw_pkg::TMW_REG_CMPA, 16'hFFFF);
      chk_rd("cmp_a", tmw_pkg::TMW_REG_CMPA, tops[i]);
      wr(tmw_pkg::TMW_REG_CMPB, 16'hFFFF);
      chk_rd("cmp_b", tmw_pkg::TMW_REG_CMPB, tops[i]);
      wr(tmw_pkg::TMW_REG_COUNT, tops[i] - 16'h0001);
      clr_flags();
      step(1);
      chk_rd("count", tmw_pkg::TMW_REG_COUNT, tops[i]);
      chk("ovf", 16'h0000, {15'h0, overflow_flag_out});
      step(1);
      chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0000);
      chk("ovf", 16'h0001, {15'h0, overflow_flag_out});
    end
  endtask

  task automatic t_fast_buf();
    wr(tmw_pkg::TMW_REG_CTRL, ctrl(tmw_pkg::TMW_MODE_CTC_A, 2'h1, 1'b1));
    wr(tmw_pkg::TMW_REG_CMPA, 16'h0004);
    wr(tmw_pkg::TMW_REG_CTRL, ctrl(tmw_pkg::TMW_MODE_FP_A, 2'h1, 1'b1));
    wr(tmw_pkg::TMW_REG_COUNT, 16'h0000);
    wr(tmw_pkg::TMW_REG_CMPA, 16'h0008);
    clr_flags();
    step(4);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0004);
    p = wave_pin_a_out;
    step(1);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0000);
    chk("flag_a", 16'h0001, {15'h0, match_flag_a_out});
    chk("ovf", 16'h0001, {15'h0, overflow_flag_out});
    chk("pin_a", {15'h0, ~p}, {15'h0, wave_pin_a_out});
    step(5);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0005);
    chk_rd("cmp_a", tmw_pkg::TMW_REG_CMPA, 16'h0008);
  endtask

  task automatic t_phase();
    wr(tmw_pkg::TMW_REG_CTRL, ctrl(tmw_pkg::TMW_MODE_CTC_A, 2'h0, 1'b1));
    wr(tmw_pkg::TMW_REG_CMPA, 16'h0002);
    wr(tmw_pkg::TMW_REG_CAPTOP, 16'h0004);
    wr(tmw_pkg::TMW_REG_CTRL, ctrl(tmw_pkg::TMW_MODE_PC_CAP, 2'h2, 1'b1));
    wr(tmw_pkg::TMW_REG_COUNT, 16'h0000);
    step(3);
    chk("pin_a", 16'h0000, {15'h0, wave_pin_a_out});
    clr_flags();
    step(1);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0004);
    step(1);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0003);
    step(2);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0001);
    chk("pin_a", 16'h0001, {15'h0, wave_pin_a_out});
    chk("ovf", 16'h0000, {15'h0, overflow_flag_out});
    step(2);
    chk_rd("count", tmw_pkg::TMW_REG_COUNT, 16'h0001);
    chk("ovf", 16'h0001, {15'h0, overflow_flag_out});
    step(2);
    chk("pin_a", 16'h0000, {15'h0, wave_pin_a_out});
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_ctc_a();
    t_ctc_cap();
    t_fast_cap();
    t_fixed_top();
    t_fast_buf();
    t_phase();
    report_and_stop();
  end
endmodule
